// File: design/sbc_interrupt_cause_flags.v
`timescale 1ns/1ps
`include "sbc_irq_regs.vh"
module sbc_interrupt_cause_flags #(
  parameter T_IRQ_OUT_N_CYCLES = `SBC_T_IRQ_OUT_N_CYC
) (
  // Clock and reset
  input wire clock,
  input wire rst,

  // Serial port
  input wire sck,
  input wire scs_n,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,

  // Interrupt line to the host
  output reg irq_out_n,

  // Operating mode and watchdog timing
  input wire normal_mode,
  input wire wdog_period_tick,

  // Event pulses
  input wire wdog_overflow_standby,
  input wire wdog_restart_off,
  input wire can_wake_event,
  input wire lin_wake_event,

  // Monitored levels
  input wire temp_warning_status,
  input wire ground_shift_diag,
  input wire battery_sense,
  input wire reg1_good,
  input wire reg2_good,
  input wire reg3_good,
  input wire can_fail_status,
  input wire lin_fail_status,
  input wire local_wake_in
);

  // ----------------------------------------------------------------
  // Level watchers
  // ----------------------------------------------------------------
  localparam NLVL = 9;
  localparam L_WAKE = 0;
  localparam L_LIN = 1;
  localparam L_CAN = 2;
  localparam L_REG3 = 3;
  localparam L_REG2 = 4;
  localparam L_REG1 = 5;
  localparam L_BAT = 6;
  localparam L_GS = 7;
  localparam L_TEMP = 8;

  wire [NLVL-1:0] lvl_in;
  wire [NLVL-1:0] lvl_change;
  wire [NLVL-1:0] lvl_fall;

  assign lvl_in = {temp_warning_status, ground_shift_diag, battery_sense,
                   reg1_good, reg2_good, reg3_good,
                   can_fail_status, lin_fail_status, local_wake_in};

  level_edge_detect #(
    .W(NLVL)
  ) u_levels (
    .clock(clock),
    .rst(rst),
    .din(lvl_in),
    .change_q(lvl_change),
    .fall_q(lvl_fall)
  );

  // ----------------------------------------------------------------
  // Serial frame port
  // ----------------------------------------------------------------
  reg [`SBC_CAUSE_W-1:0] cause_q;
  reg [`SBC_CAUSE_W-1:0] cause_d;
  wire [`SBC_FRAME_BITS-1:0] sent_word;
  wire [`SBC_FRAME_BITS-1:0] rx_word;
  wire frame_done;
  wire frame_ok;
  wire sdo_w;
  wire sdo_oe_w;

  serial_frame_port u_port (
    .clock(clock),
    .rst(rst),
    .sck(sck),
    .scs_n(scs_n),
    .sdi(sdi),
    .sdo_q(sdo_w),
    .sdo_oe_q(sdo_oe_w),
    .tx_word(cause_q),
    .tx_hold_q(sent_word),
    .rx_word_q(rx_word),
    .done_q(frame_done),
    .ok_q(frame_ok)
  );

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // The read-only bit only guards writes to the enable register,
  // which lives outside this block, so a cause read clears either way.
  function addr_is_cause;
    input [`SBC_FRAME_BITS-1:0] word;
    begin
      addr_is_cause = (word[`SBC_ADDR_HI:`SBC_ADDR_LO] == `SBC_ADDR_CAUSE);
    end
  endfunction

  wire read_cause = frame_done & frame_ok & addr_is_cause(rx_word);
  wire bad_frame = frame_done & ~frame_ok;

  // ----------------------------------------------------------------
  // Event sets
  // ----------------------------------------------------------------
  reg [`SBC_CAUSE_W-1:0] set_vec;

  always @* begin
    set_vec = `SBC_CAUSE_RESET;
    set_vec[`SBC_BIT_WDOG_TIMEOUT] = wdog_overflow_standby;
    set_vec[`SBC_BIT_OVERTEMP] = lvl_change[L_TEMP];
    set_vec[`SBC_BIT_GROUND_SHIFT] = lvl_change[L_GS];
    set_vec[`SBC_BIT_SERIAL_FAIL] = bad_frame;
    set_vec[`SBC_BIT_BATTERY_FAIL] = lvl_fall[L_BAT];
    set_vec[`SBC_BIT_REG_FAIL] = lvl_fall[L_REG1] | lvl_fall[L_REG2] |
                                 lvl_fall[L_REG3];
    set_vec[`SBC_BIT_CAN_FAIL] = lvl_change[L_CAN];
    set_vec[`SBC_BIT_LIN_FAIL] = lvl_change[L_LIN];
    set_vec[`SBC_BIT_LOCAL_WAKE] = lvl_fall[L_WAKE];
    set_vec[`SBC_BIT_WDOG_RESTART] = wdog_restart_off;
    set_vec[`SBC_BIT_CAN_WAKE] = can_wake_event;
    set_vec[`SBC_BIT_LIN_WAKE] = lin_wake_event;
  end

  // ----------------------------------------------------------------
  // Cause word
  // ----------------------------------------------------------------
  // Only bits actually shifted out are cleared, and a set in the same
  // cycle wins, so an event during the read survives to the next one.
  always @* begin
    cause_d = cause_q;
    if (read_cause)
      cause_d = cause_q & ~sent_word;
    cause_d = cause_d | set_vec;
  end

  always @(posedge clock) begin
    if (rst)
      cause_q <= `SBC_CAUSE_RESET;
    else
      cause_q <= cause_d;
  end

  // ----------------------------------------------------------------
  // Interrupt throttle
  // ----------------------------------------------------------------
  reg asserted_q;
  reg nonurg_ok_q;
  reg [`SBC_REL_CNT_W-1:0] rel_cnt_q;
  wire [`SBC_CAUSE_W-1:0] urgent_mask = `SBC_URGENT_MASK;
  wire urgent_pend = |(cause_q & urgent_mask);
  wire nonurg_pend = |(cause_q & ~urgent_mask);
  wire nonurg_allow = ~normal_mode | nonurg_ok_q;
  wire irq_req = urgent_pend | (nonurg_pend & nonurg_allow);

  // Outside normal mode nothing is throttled; the budget refills each
  // watchdog period and is spent by a non-urgent assertion.
  always @(posedge clock) begin
    if (rst) begin
      nonurg_ok_q <= 1'b1;
    end else if (wdog_period_tick) begin
      nonurg_ok_q <= 1'b1;
    end else if (normal_mode & ~asserted_q & ~urgent_pend & nonurg_pend &
                 nonurg_ok_q & (rel_cnt_q == {`SBC_REL_CNT_W{1'b0}})) begin
      nonurg_ok_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  localparam [`SBC_REL_CNT_W-1:0] REL_LOAD = T_IRQ_OUT_N_CYCLES[`SBC_REL_CNT_W-1:0];
  wire releasing = (rel_cnt_q != {`SBC_REL_CNT_W{1'b0}});

  // A held-low line would hide later events, so each read forces a
  // high gap; any urgent or unthrottled cause left pending then pulls it low again.
  always @(posedge clock) begin
    if (rst) begin
      rel_cnt_q <= {`SBC_REL_CNT_W{1'b0}};
      asserted_q <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      if (read_cause) begin
        rel_cnt_q <= REL_LOAD;
        asserted_q <= 1'b0;
        irq_out_n <= 1'b1;
      end else if (releasing) begin
        rel_cnt_q <= rel_cnt_q - 8'h01;
        irq_out_n <= 1'b1;
      end else begin
        if (irq_req)
          asserted_q <= 1'b1;
        irq_out_n <= ~(asserted_q | irq_req);
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo <= sdo_w;
      sdo_oe <= sdo_oe_w;
    end
  end

endmodule

// File: design/sbc_irq_regs.vh
`ifndef SBC_IRQ_REGS_VH
`define SBC_IRQ_REGS_VH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SBC_FRAME_BITS 16
`define SBC_BITCNT_W 5
`define SBC_BITCNT_MAX 5'h11
`define SBC_FRAME_LEN 5'h10
`define SBC_ADDR_HI 15
`define SBC_ADDR_LO 14
`define SBC_RRS_BIT 13
`define SBC_RO_BIT 12
`define SBC_ADDR_CAUSE 2'h1

// ----------------------------------------------------------------
// Cause word
// ----------------------------------------------------------------
`define SBC_CAUSE_W 16
`define SBC_CAUSE_RESET 16'h0000
`define SBC_BIT_WDOG_TIMEOUT 11
`define SBC_BIT_OVERTEMP 10
`define SBC_BIT_GROUND_SHIFT 9
`define SBC_BIT_SERIAL_FAIL 8
`define SBC_BIT_BATTERY_FAIL 7
`define SBC_BIT_REG_FAIL 6
`define SBC_BIT_CAN_FAIL 5
`define SBC_BIT_LIN_FAIL 4
`define SBC_BIT_LOCAL_WAKE 3
`define SBC_BIT_WDOG_RESTART 2
`define SBC_BIT_CAN_WAKE 1
`define SBC_BIT_LIN_WAKE 0
// Bits that bypass the once-per-watchdog-period throttle
`define SBC_URGENT_MASK 16'h0984

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBC_CLK_PERIOD_NS 100
`define SBC_T_IRQ_OUT_N_NS 2000
`define SBC_T_IRQ_OUT_N_CYC \
  ((`SBC_T_IRQ_OUT_N_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_REL_CNT_W 8

`endif

// File: design/level_edge_detect.v
`timescale 1ns/1ps
module level_edge_detect #(
  parameter W = 9
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Levels watched
  input wire [W-1:0] din,
  // One-cycle event pulses
  output reg [W-1:0] change_q,
  output reg [W-1:0] fall_q
);

  reg [W-1:0] prev_q;

  // Reset loads the live level so start-up does not fake an edge
  always @(posedge clock) begin
    if (rst) begin
      prev_q <= din;
      change_q <= {W{1'b0}};
      fall_q <= {W{1'b0}};
    end else begin
      prev_q <= din;
      change_q <= din ^ prev_q;
      fall_q <= prev_q & ~din;
    end
  end

endmodule

// File: design/serial_frame_port.v
`timescale 1ns/1ps
`include "sbc_irq_regs.vh"
module serial_frame_port (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Serial pins
  input wire sck,
  input wire scs_n,
  input wire sdi,
  output reg sdo_q,
  output reg sdo_oe_q,
  // Word offered at frame start
  input wire [`SBC_FRAME_BITS-1:0] tx_word,
  // Frame results
  output reg [`SBC_FRAME_BITS-1:0] tx_hold_q,
  output reg [`SBC_FRAME_BITS-1:0] rx_word_q,
  output reg done_q,
  output reg ok_q
);

  reg sck_q;
  reg scs_n_q;
  reg [`SBC_BITCNT_W-1:0] cnt_q;
  reg [`SBC_FRAME_BITS-1:0] shift_q;
  wire start = scs_n_q & ~scs_n;
  wire stop = ~scs_n_q & scs_n;
  wire rise = ~scs_n & ~sck_q & sck;
  wire fall = ~scs_n & sck_q & ~sck;

  // ----------------------------------------------------------------
  // Shift and clock count
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      sck_q <= 1'b0;
      scs_n_q <= 1'b1;
      cnt_q <= {`SBC_BITCNT_W{1'b0}};
      shift_q <= {`SBC_FRAME_BITS{1'b0}};
      tx_hold_q <= {`SBC_FRAME_BITS{1'b0}};
      rx_word_q <= {`SBC_FRAME_BITS{1'b0}};
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      sck_q <= sck;
      scs_n_q <= scs_n;
      done_q <= stop;
      sdo_oe_q <= ~scs_n;
      if (start) begin
        cnt_q <= {`SBC_BITCNT_W{1'b0}};
        tx_hold_q <= tx_word;
        shift_q <= tx_word;
        sdo_q <= tx_word[`SBC_FRAME_BITS-1];
      end else begin
        if (rise) begin
          rx_word_q <= {rx_word_q[`SBC_FRAME_BITS-2:0], sdi};
          // Saturate so long frames never wrap back to a legal count
          if (cnt_q != `SBC_BITCNT_MAX)
            cnt_q <= cnt_q + 5'h01;
        end
        if (fall) begin
          shift_q <= {shift_q[`SBC_FRAME_BITS-2:0], 1'b0};
          sdo_q <= shift_q[`SBC_FRAME_BITS-2];
        end
      end
      if (stop)
        ok_q <= (cnt_q == `SBC_FRAME_LEN);
    end
  end

endmodule

// File: tb/irq_cause_monitor.sv
`timescale 1ns/1ps
module irq_cause_monitor #(
  parameter T_IRQ_OUT_N_CYCLES = 20
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Outputs watched
  input wire irq_out_n,
  input wire sdo,
  input wire sdo_oe,
  // Causes
  input wire normal_mode,
  input wire wdog_overflow_standby,
  input wire wdog_restart_off,
  input wire can_wake_event,
  input wire lin_wake_event,
  input wire battery_sense,
  input wire local_wake_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Bound covers the release window after a read plus the flag latency
  sequence irq_soon;
    ##[1:30] !irq_out_n;
  endsequence
  sequence held_high;
    irq_out_n [*3];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  overflow_irq_a: assert property (wdog_overflow_standby |-> irq_soon)
    else $error("standby overflow gave no interrupt");
  restart_irq_a: assert property (wdog_restart_off |-> irq_soon)
    else $error("watchdog restart gave no interrupt");
  battery_irq_a: assert property ($fell(battery_sense) |-> irq_soon)
    else $error("battery fall gave no interrupt");
  can_wake_a: assert property (!normal_mode && can_wake_event |-> irq_soon)
    else $error("can wake gave no interrupt");
  lin_wake_a: assert property (!normal_mode && lin_wake_event |-> irq_soon)
    else $error("lin wake gave no interrupt");
  local_wake_a: assert property (!normal_mode && $fell(local_wake_in) |-> irq_soon)
    else $error("local wake fall gave no interrupt");
  reset_state_a: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> irq_out_n && !sdo && !sdo_oe) else $error("outputs not idle in reset");
  release_hold_a: assert property ($rose(irq_out_n) |-> held_high)
    else $error("interrupt release too short");
endmodule

bind sbc_interrupt_cause_flags irq_cause_monitor #(.T_IRQ_OUT_N_CYCLES(T_IRQ_OUT_N_CYCLES))
  u_irq_cause_monitor (.clock, .rst, .irq_out_n, .sdo, .sdo_oe, .normal_mode,
  .wdog_overflow_standby, .wdog_restart_off, .can_wake_event, .lin_wake_event,
  .battery_sense, .local_wake_in);

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire clock,
  // Serial pins
  output logic sck,
  output logic scs_n,
  output logic sdi,
  input wire sdo
);
  initial begin
    sck = 1'b0;
    scs_n = 1'b1;
    sdi = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Frame of n clocks, sdo taken before each rising sck
  // ----------------------------------------------------------------
  task automatic xfer(input int n, output logic [15:0] r);
    logic [15:0] w;
    w = 16'h5000;
    r = 16'h0000;
    step(1);
    scs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[15 - (i % 16)];
      step(4);
      r = {r[14:0], sdo};
      sck = 1'b1;
      step(4);
      sck = 1'b0;
    end
    step(4);
    scs_n = 1'b1;
    // A released line must not keep showing the last bit
    sdi = ~sdi;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock, rst, sck, scs_n, sdi, sdo, sdo_oe, irq_out_n, normal_mode, wdog_period_tick;
  logic wdog_overflow_standby, wdog_restart_off, can_wake_event, lin_wake_event;
  logic temp_warning_status, ground_shift_diag, battery_sense, reg1_good, reg2_good;
  logic reg3_good, can_fail_status, lin_fail_status, local_wake_in;
  logic [15:0] r;
  int miscompares = 0;
  int n_checks = 0;

  sbc_interrupt_cause_flags #(.T_IRQ_OUT_N_CYCLES(4)) u_sbc_interrupt_cause_flags (.clock, .rst,
    .sck, .scs_n, .sdi, .sdo, .sdo_oe, .irq_out_n, .normal_mode, .wdog_period_tick,
    .wdog_overflow_standby, .wdog_restart_off, .can_wake_event, .lin_wake_event,
    .temp_warning_status, .ground_shift_diag, .battery_sense, .reg1_good, .reg2_good,
    .reg3_good, .can_fail_status, .lin_fail_status, .local_wake_in);
  spi_host_model host (.clock, .sck, .scs_n, .sdi, .sdo);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] exp);
    host.xfer(16, r);
    check(r, exp);
    tick(5);
    check({15'h0, irq_out_n}, 16'h1);
    tick(10);
  endtask
  task automatic fire(input int k, input int p, input logic irq);
    case (k)
      0: lin_wake_event = 1'b1;
      1: can_wake_event = 1'b1;
      2: wdog_restart_off = 1'b1;
      3: local_wake_in = 1'b0;
      4: lin_fail_status = ~lin_fail_status;
      5: can_fail_status = ~can_fail_status;
      6: {reg3_good, reg2_good, reg1_good} = ~(3'h1 << p);
      7: battery_sense = 1'b0;
      9: ground_shift_diag = ~ground_shift_diag;
      10: temp_warning_status = ~temp_warning_status;
      default: wdog_overflow_standby = 1'b1;
    endcase
    tick(1);
    {lin_wake_event, can_wake_event, wdog_restart_off, wdog_overflow_standby} = 4'h0;
    tick(3);
    check({15'h0, irq_out_n}, {15'h0, irq});
  endtask
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #3000000;
    miscompares++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {normal_mode, wdog_period_tick, wdog_overflow_standby, wdog_restart_off} = 4'h0;
    {can_wake_event, lin_wake_event, temp_warning_status, ground_shift_diag} = 4'h0;
    {can_fail_status, lin_fail_status} = 2'h0;
    {battery_sense, reg1_good, reg2_good, reg3_good, local_wake_in} = 5'h1f;
    tick(8);
    rst = 1'b0;
    tick(2);
    // Reg fall and bad length vary with the pass; change flags flip both ways
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 12; k++) begin
        if (k == 8) begin
          host.xfer(p == 1 ? 17 : 15, r);
          tick(5);
          check({15'h0, irq_out_n}, 16'h0);
          rd(16'h0100);
        end else begin
          fire(k, p, 1'b0);
          rd(16'h0001 << k);
        end
        {battery_sense, reg1_good, reg2_good, reg3_good, local_wake_in} = 5'h1f;
        // Let the restored levels settle before the next event touches them
        tick(1);
      end
    end
    rd(16'h0000);
    $display("test flags done");
    fire(11, 0, 1'b0);
    host.xfer(17, r);
    tick(5);
    rd(16'h0900);
    // An event landing after the snapshot must survive the clear
    fork
      host.xfer(16, r);
      begin
        tick(20);
        can_wake_event = 1'b1;
        tick(1);
        can_wake_event = 1'b0;
      end
    join
    check(r, 16'h0000);
    tick(15);
    check({15'h0, irq_out_n}, 16'h0);
    rd(16'h0002);
    $display("test bad frame done");
    normal_mode = 1'b1;
    fire(1, 0, 1'b0);
    rd(16'h0002);
    fire(0, 0, 1'b1);
    tick(10);
    check({15'h0, irq_out_n}, 16'h1);
    wdog_period_tick = 1'b1;
    tick(1);
    wdog_period_tick = 1'b0;
    tick(3);
    check({15'h0, irq_out_n}, 16'h0);
    rd(16'h0001);
    $display("test throttle done");
    end_sim();
  end
endmodule
